// ### design/tccd_pkg.sv
// package: register map, field positions, reset values for timer channels
package tccd_pkg;
   // sfr addresses
   localparam logic [7:0] ADDR_CH0_VALUE_LOW = 8'hda;
   localparam logic [7:0] ADDR_CH0_VALUE_HIGH = 8'hdb;
   localparam logic [7:0] ADDR_CH1_VALUE_LOW = 8'hdc;
   localparam logic [7:0] ADDR_CH1_VALUE_HIGH = 8'hdd;
   localparam logic [7:0] ADDR_CH2_VALUE_LOW = 8'hde;
   localparam logic [7:0] ADDR_CH2_VALUE_HIGH = 8'hdf;
   localparam logic [7:0] ADDR_CH0_CONTROL = 8'he5;
   localparam logic [7:0] ADDR_CH1_CONTROL = 8'he6;
   localparam logic [7:0] ADDR_CH2_CONTROL = 8'he7;
   localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'he4;
   localparam logic [7:0] ADDR_RADIO_EVENT_MASK = 8'he3;
   // control field positions
   localparam int CTL_SRC_BIT = 7;
   localparam int CTL_MASK_BIT = 6;
   localparam int CTL_CMP_LSB = 3;
   localparam int CTL_MODE_BIT = 2;
   localparam int CTL_CAP_LSB = 0;
   // reset values
   localparam logic [7:0] CTL_RESET = 8'h40;
   localparam logic [7:0] VALUE_RESET = 8'h00;
   localparam logic [7:0] CNT_CTL_RESET = 8'h00;
   localparam logic [7:0] RADIO_EVENT_MASK_RESET = 8'h00;
   localparam logic [15:0] COUNT_TOP = 16'hffff;
   // modulator clock dividers
   localparam logic [2:0] DSM_DIV_SLOW = 3'h7;
   localparam logic [2:0] DSM_DIV_FAST = 3'h3;
   // compare action codes
   localparam logic [2:0] CMP_SET = 3'h0;
   localparam logic [2:0] CMP_CLR = 3'h1;
   localparam logic [2:0] CMP_TGL = 3'h2;
   localparam logic [2:0] CMP_SET_UP = 3'h3;
   localparam logic [2:0] CMP_CLR_UP = 3'h4;
   localparam logic [2:0] CMP_SET_CH0 = 3'h5;
   localparam logic [2:0] CMP_CLR_CH0 = 3'h6;
   localparam logic [2:0] CMP_DSM = 3'h7;
   // counter modes
   localparam logic [1:0] CNT_STOP = 2'h0;
   localparam logic [1:0] CNT_FREE = 2'h1;
   localparam logic [1:0] CNT_MOD = 2'h2;
   localparam logic [1:0] CNT_UPDN = 2'h3;
   typedef struct packed {
      logic [2:0][7:0] ctl;
      logic [2:0][15:0] value;
      logic [7:0] cnt_ctl;
      logic [7:0] radio_event_mask;
      logic [15:0] count;
      logic down;
      logic [2:0] cap_s1;
      logic [2:0] cap_s2;
      logic [2:0] cap_old;
      logic [2:0] out;
      logic [2:0] flag;
      logic [7:0] rdata;
      logic [2:0] dsm_div;
      logic [15:0] dsm_rate;
      logic [16:0] dsm_acc;
      logic dsm_out;
   } tccd_state_t;
endpackage

// ### design/tccd_channels.sv
// capture/compare channels with counter and modulator output
// Contract
// - each channel holds a 16-bit value in high and low byte registers, reset zero
// - in modulator mode the channel 0 value sets the modulator sample rate
// - source select 0 uses capture pin, 1 uses masked radio events
// - per-channel interrupt mask bit resets to 1, enabling the interrupt
// - match action: 000 set, 001 clear, 010 toggle
// - code 011: set on up match, clear at zero or on down match
// - code 100: clear on up match, set at zero or on down match
// - channels 1,2 code 101: set at own value, clear at channel 0 value
// - channels 1,2 code 110: clear at own value, set at channel 0 value
// - channel 1 code 111 is modulator mode; mode bit picks 1/8 or 1/4 rate
// - outside modulator mode, mode bit 0 capture, 1 compare
// - edge field: 00 off, 01 rising, 10 falling, 11 both
// - modulator edge field selects interpolator and shaping enables
// - modulator data is channel 1 value with two low bits ignored
// - counter modes: stopped, free 16-bit, modulo to ch0, up/down to ch0
// - channel 0 codes 101 to 111 reserved, no action
`timescale 1ns/1ps
`default_nettype none
module tccd_channels
   import tccd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [2:0] capture_pin,
   input wire logic [7:0] radio_event,
   output logic [2:0] compare_out,
   output logic [2:0] channel_flag,
   output logic [2:0] channel_irq,
   output logic dsm_out,
   output logic dsm_interp_en,
   output logic dsm_shaping_en
);
   tccd_state_t s_reg, s_next;

   function automatic logic [1:0] cap_field(input logic [7:0] c);
      cap_field = c[CTL_CAP_LSB+:2];
   endfunction

   function automatic logic [2:0] cmp_field(input logic [7:0] c);
      cmp_field = c[CTL_CMP_LSB+:3];
   endfunction

   logic dsm_mode;
   assign dsm_mode = cmp_field(s_reg.ctl[1]) == CMP_DSM;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [15:0] top;
      logic at_top;
      logic at_zero;
      logic tick;
      logic [2:0] cap_now;
      logic rf_hit;
      logic edge_hit;
      logic match;
      logic match0;
      logic [2:0] act;
      logic [15:0] dsm_data;
      s_next = s_reg;
      top = COUNT_TOP;
      at_top = 1'b0;
      at_zero = 1'b0;
      tick = 1'b0;
      cap_now = '0;
      rf_hit = 1'b0;
      edge_hit = 1'b0;
      match = 1'b0;
      match0 = 1'b0;
      act = '0;
      dsm_data = '0;
      // pins through two flops
      s_next.cap_s1 = capture_pin;
      s_next.cap_s2 = s_reg.cap_s1;
      s_next.cap_old = s_reg.cap_s2;
      cap_now = s_reg.cap_s2;
      rf_hit = |(radio_event & s_reg.radio_event_mask);
      // counter
      if (s_reg.cnt_ctl[1:0] != CNT_FREE) begin
         top = s_reg.value[0];
      end
      at_top = s_reg.count == top;
      at_zero = s_reg.count == 16'h0000;
      tick = s_reg.cnt_ctl[1:0] != CNT_STOP;
      if (tick) begin
         case (s_reg.cnt_ctl[1:0])
            CNT_FREE, CNT_MOD: begin
               s_next.count = at_top ? 16'h0000 : s_reg.count + 16'h0001;
            end
            CNT_UPDN: begin
               if (!s_reg.down && at_top) begin
                  s_next.down = 1'b1;
                  s_next.count = s_reg.count - 16'h0001;
               end else if (s_reg.down && at_zero) begin
                  s_next.down = 1'b0;
                  s_next.count = s_reg.count + 16'h0001;
               end else if (s_reg.down) begin
                  s_next.count = s_reg.count - 16'h0001;
               end else begin
                  s_next.count = s_reg.count + 16'h0001;
               end
            end
            default: begin
               s_next.count = s_reg.count;
            end
         endcase
      end
      if (s_reg.cnt_ctl[1:0] != CNT_UPDN) begin
         s_next.down = 1'b0;
      end
      match0 = tick && s_reg.count == s_reg.value[0];
      // channels
      for (int i = 0; i < 3; i++) begin
         act = cmp_field(s_reg.ctl[i]);
         match = tick && s_reg.count == s_reg.value[i];
         if (i == 1 && dsm_mode) begin
            // modulator owns the channel
         end else if (s_reg.ctl[i][CTL_MODE_BIT]) begin
            if (match) begin
               s_next.flag[i] = 1'b1;
            end
            case (act)
               CMP_SET: if (match) s_next.out[i] = 1'b1;
               CMP_CLR: if (match) s_next.out[i] = 1'b0;
               CMP_TGL: if (match) s_next.out[i] = ~s_reg.out[i];
               CMP_SET_UP: begin
                  if (match) s_next.out[i] = !s_reg.down;
                  else if (at_zero && tick) s_next.out[i] = 1'b0;
               end
               CMP_CLR_UP: begin
                  if (match) s_next.out[i] = s_reg.down;
                  else if (at_zero && tick) s_next.out[i] = 1'b1;
               end
               CMP_SET_CH0: begin
                  if (i != 0 && match) s_next.out[i] = 1'b1;
                  else if (i != 0 && match0) s_next.out[i] = 1'b0;
               end
               CMP_CLR_CH0: begin
                  if (i != 0 && match) s_next.out[i] = 1'b0;
                  else if (i != 0 && match0) s_next.out[i] = 1'b1;
               end
               default: s_next.out[i] = s_reg.out[i];
            endcase
         end else begin
            case (cap_field(s_reg.ctl[i]))
               2'h1: edge_hit = cap_now[i] && !s_reg.cap_old[i];
               2'h2: edge_hit = !cap_now[i] && s_reg.cap_old[i];
               2'h3: edge_hit = cap_now[i] != s_reg.cap_old[i];
               default: edge_hit = 1'b0;
            endcase
            if (s_reg.ctl[i][CTL_SRC_BIT]) begin
               edge_hit = rf_hit && cap_field(s_reg.ctl[i]) != 2'h0;
            end
            if (edge_hit) begin
               s_next.value[i] = s_reg.count;
               s_next.flag[i] = 1'b1;
            end
         end
      end
      // modulator: first-order accumulator paced by a divider
      if (dsm_mode) begin
         if (s_reg.dsm_div == 3'h0) begin
            s_next.dsm_div = s_reg.ctl[1][CTL_MODE_BIT] ? DSM_DIV_FAST
               : DSM_DIV_SLOW;
            if (s_reg.dsm_rate == 16'h0000) begin
               s_next.dsm_rate = s_reg.value[0];
               dsm_data = {s_reg.value[1][15:2], 2'b00};
               s_next.dsm_acc = {1'b0, s_reg.dsm_acc[15:0]}
                  + {1'b0, dsm_data};
               s_next.dsm_out = s_next.dsm_acc[16];
            end else begin
               s_next.dsm_rate = s_reg.dsm_rate - 16'h0001;
            end
         end else begin
            s_next.dsm_div = s_reg.dsm_div - 3'h1;
         end
      end else begin
         s_next.dsm_div = '0;
         s_next.dsm_rate = '0;
         s_next.dsm_acc = '0;
         s_next.dsm_out = 1'b0;
      end
      // ------------------------------------------------------------
      // register writes; hardware capture wins over software write when the channel flag was clear
      // ------------------------------------------------------------
      if (sfr_wr) begin
         case (sfr_addr)
            ADDR_CH0_VALUE_LOW: s_next.value[0][7:0] = sfr_wdata;
            ADDR_CH0_VALUE_HIGH: s_next.value[0][15:8] = sfr_wdata;
            ADDR_CH1_VALUE_LOW: s_next.value[1][7:0] = sfr_wdata;
            ADDR_CH1_VALUE_HIGH: s_next.value[1][15:8] = sfr_wdata;
            ADDR_CH2_VALUE_LOW: s_next.value[2][7:0] = sfr_wdata;
            ADDR_CH2_VALUE_HIGH: s_next.value[2][15:8] = sfr_wdata;
            ADDR_CH0_CONTROL: s_next.ctl[0] = sfr_wdata;
            ADDR_CH1_CONTROL: s_next.ctl[1] = sfr_wdata;
            ADDR_CH2_CONTROL: s_next.ctl[2] = sfr_wdata;
            ADDR_COUNTER_CONTROL: begin
               s_next.cnt_ctl = sfr_wdata;
               // flags in bits 7:5 clear on write of 0, a set wins only when the flag was clear
               s_next.flag = s_next.flag & (sfr_wdata[7:5] | s_next.flag
                  & ~s_reg.flag);
            end
            ADDR_RADIO_EVENT_MASK: s_next.radio_event_mask = sfr_wdata;
            default: s_next.radio_event_mask = s_next.radio_event_mask;
         endcase
         if (sfr_addr inside {ADDR_CH0_VALUE_LOW, ADDR_CH0_VALUE_HIGH,
               ADDR_CH1_VALUE_LOW, ADDR_CH1_VALUE_HIGH,
               ADDR_CH2_VALUE_LOW, ADDR_CH2_VALUE_HIGH}) begin
            for (int i = 0; i < 3; i++) begin
               if (!s_reg.ctl[i][CTL_MODE_BIT] && !(i == 1 && dsm_mode)
                     && s_reg.value[i] != s_next.value[i]
                     && s_next.flag[i] && !s_reg.flag[i]) begin
                  s_next.value[i] = s_reg.count;
               end
            end
         end
      end
      // read data
      case (sfr_addr)
         ADDR_CH0_VALUE_LOW: s_next.rdata = s_reg.value[0][7:0];
         ADDR_CH0_VALUE_HIGH: s_next.rdata = s_reg.value[0][15:8];
         ADDR_CH1_VALUE_LOW: s_next.rdata = s_reg.value[1][7:0];
         ADDR_CH1_VALUE_HIGH: s_next.rdata = s_reg.value[1][15:8];
         ADDR_CH2_VALUE_LOW: s_next.rdata = s_reg.value[2][7:0];
         ADDR_CH2_VALUE_HIGH: s_next.rdata = s_reg.value[2][15:8];
         ADDR_CH0_CONTROL: s_next.rdata = s_reg.ctl[0];
         ADDR_CH1_CONTROL: s_next.rdata = s_reg.ctl[1];
         ADDR_CH2_CONTROL: s_next.rdata = s_reg.ctl[2];
         ADDR_COUNTER_CONTROL: s_next.rdata = {s_reg.flag,
            s_reg.cnt_ctl[4:0]};
         ADDR_RADIO_EVENT_MASK: s_next.rdata = s_reg.radio_event_mask;
         default: s_next.rdata = 8'h00;
      endcase
      if (!sfr_rd) begin
         s_next.rdata = s_reg.rdata;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.ctl <= {3{CTL_RESET}};
         s_reg.value <= {6{VALUE_RESET}};
         s_reg.cnt_ctl <= CNT_CTL_RESET;
         s_reg.radio_event_mask <= RADIO_EVENT_MASK_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign sfr_rdata = s_reg.rdata;
   assign compare_out = s_reg.out;
   assign channel_flag = s_reg.flag;
   assign dsm_out = s_reg.dsm_out;
   // edge field 01 keeps interpolator only, 10 keeps shaping only
   assign dsm_interp_en = dsm_mode && !s_reg.ctl[1][CTL_CAP_LSB+1];
   assign dsm_shaping_en = dsm_mode && !s_reg.ctl[1][CTL_CAP_LSB];
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         channel_irq[i] = s_reg.flag[i] && s_reg.ctl[i][CTL_MASK_BIT];
      end
   end
endmodule
`default_nettype wire

// ### verif/tccd_pins_model.sv
// partner model: capture pins and radio event sources
`timescale 1ns/1ps
`default_nettype none
module tccd_pins_model (
   input wire logic clk,
   output logic [2:0] capture_pin,
   output logic [7:0] radio_event
);
   initial begin
      capture_pin = 3'h0;
      radio_event = 8'h00;
   end
   task automatic set_pin(input int ch, input logic lvl);
      @(negedge clk);
      capture_pin[ch] = lvl;
   endtask
   // radio events are single-cycle pulses
   task automatic fire(input logic [7:0] ev);
      @(negedge clk);
      radio_event = ev;
      @(negedge clk);
      radio_event = 8'h00;
   endtask
endmodule
`default_nettype wire

// ### verif/tccd_channels_props.sv
// checker: port-level properties of the timer channels
`timescale 1ns/1ps
`default_nettype none
module tccd_channels_props
   import tccd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [2:0] capture_pin,
   input wire logic [7:0] radio_event,
   input wire logic [2:0] compare_out,
   input wire logic [2:0] channel_flag,
   input wire logic [2:0] channel_irq,
   input wire logic dsm_out,
   input wire logic dsm_interp_en,
   input wire logic dsm_shaping_en
);
   // ----------------------------------------
   // shadow copies of written controls
   // ----------------------------------------
   logic [7:0] c1_reg, c2_reg, rf_reg;
   wire logic mapped = sfr_addr inside {[8'hda:8'hdf], [8'he3:8'he7]};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c1_reg <= CTL_RESET;
         c2_reg <= CTL_RESET;
         rf_reg <= RADIO_EVENT_MASK_RESET;
      end else if (sfr_wr) begin
         if (sfr_addr == ADDR_CH1_CONTROL) c1_reg <= sfr_wdata;
         if (sfr_addr == ADDR_CH2_CONTROL) c2_reg <= sfr_wdata;
         if (sfr_addr == ADDR_RADIO_EVENT_MASK) rf_reg <= sfr_wdata;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_irq_gate: assert property (
      channel_irq[2:1] == (channel_flag[2:1] & {c2_reg[6], c1_reg[6]}))
      else $error("irq does not follow flag and mask");
   a_ctl_read: assert property (
      sfr_rd && !sfr_wr && sfr_addr == ADDR_CH1_CONTROL
      |=> sfr_rdata == $past(c1_reg)) else $error("control read wrong");
   a_unmapped_read: assert property (
      sfr_rd && !mapped |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_value_echo: assert property (
      sfr_wr && sfr_addr == ADDR_CH0_VALUE_LOW ##1 sfr_rd && !sfr_wr &&
      sfr_addr == ADDR_CH0_VALUE_LOW |=> sfr_rdata == $past(sfr_wdata, 2))
      else $error("value byte not read back");
   a_flag_sticky: assert property (
      !$past(sfr_wr && sfr_addr == ADDR_COUNTER_CONTROL)
      |-> (channel_flag & $past(channel_flag)) == $past(channel_flag))
      else $error("flag dropped without clear");
   a_dsm_rate: assert property (
      $changed(dsm_out) |=> $stable(dsm_out) [*3])
      else $error("modulator bit faster than quarter rate");
   a_dsm_config: assert property (
      c1_reg[5:3] == CMP_DSM |-> dsm_interp_en == !c1_reg[1] &&
      dsm_shaping_en == !c1_reg[0]) else $error("modulator config wrong");
   a_radio_capture: assert property (
      c2_reg[7] && !c2_reg[2] && c2_reg[1:0] != 2'h0 &&
      |(radio_event & rf_reg) |-> ##[1:2] channel_flag[2])
      else $error("radio capture missed");
   a_pin_capture: assert property (
      $rose(capture_pin[1]) && c1_reg[1:0] == 2'h1 && c1_reg[7:2] != 6'h1f
      && !c1_reg[7] && !c1_reg[2] |-> ##[2:5] channel_flag[1])
      else $error("pin capture missed");
endmodule
bind tccd_channels tccd_channels_props u_props (.clk, .rst_n, .sfr_addr,
   .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .capture_pin, .radio_event,
   .compare_out, .channel_flag, .channel_irq, .dsm_out, .dsm_interp_en,
   .dsm_shaping_en);
`default_nettype wire

// ### verif/tb.sv
// testbench: registers, compare, capture and modulator scenarios
`timescale 1ns/1ps
`default_nettype none
module tb
   import tccd_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic chk = 1'b0, rd_d = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, junk;
   logic [7:0] radio_event;
   logic [2:0] capture_pin, compare_out, channel_flag, channel_irq;
   logic dsm_out, dsm_interp_en, dsm_shaping_en;
   logic [7:0] exp_q[$];
   logic [15:0] v0, v1, v2;
   int mismatches = 0, total_checks = 0, n;
   int tab[13][5] = '{'{0, 2, 0, 0, 1}, '{0, 2, 5, 0, 1},
      '{1, 2, 0, 0, 1}, '{1, 2, 1, 0, 0}, '{1, 2, 2, 1, 32},
      '{2, 2, 0, 0, 1}, '{2, 2, 7, 0, 1},
      '{1, 2, 3, 1, 22}, '{2, 2, 4, 1, 10},
      '{1, 2, 5, 1, 21}, '{2, 2, 6, 1, 11},
      '{1, 3, 3, 1, 42}, '{2, 3, 4, 1, 20}};
   tccd_channels u_tccd_channels (.clk, .rst_n, .sfr_addr, .sfr_wr,
      .sfr_rd, .sfr_wdata, .sfr_rdata, .capture_pin, .radio_event,
      .compare_out, .channel_flag, .channel_irq, .dsm_out, .dsm_interp_en,
      .dsm_shaping_en);
   tccd_pins_model u_tccd_pins_model (.clk, .capture_pin, .radio_event);
   initial forever #12.5 clk = ~clk;
   // ----------------------------------------
   // bus tasks and comparison
   // ----------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e, input logic c,
      output logic [7:0] v);
      if (c) exp_q.push_back(e);
      sfr_addr = a;
      chk = c;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      @(negedge clk);
      v = sfr_rdata;
   endtask
   task automatic hi_len(input int ch, output int len);
      len = 0;
      while (compare_out[ch] !== 1'b0 && len < 200) @(negedge clk) len++;
      while (compare_out[ch] !== 1'b1 && len < 400) @(negedge clk) len++;
      len = 0;
      while (compare_out[ch] === 1'b1 && len < 200) @(negedge clk) len++;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      rd_d <= sfr_rd && chk;
      if (rd_d) check("sfr_rdata", sfr_rdata, exp_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      final_report();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(43629));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(8'hda + i), VALUE_RESET, 1, junk);
      for (int i = 0; i < 3; i++) rd(8'(8'he5 + i), CTL_RESET, 1, junk);
      rd(8'h80, 8'h00, 1, junk);
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         v0 = 16'($urandom);
         wr(8'(8'hda + i), v0[7:0]);
         rd(8'(8'hda + i), v0[7:0], 1, junk);
      end
      $display("test value readback done");
      wr(ADDR_CH0_VALUE_LOW, 8'h1f);
      wr(ADDR_CH0_VALUE_HIGH, 8'h00);
      for (int i = 0; i < 4; i++) wr(8'(8'hdc + i), i[0] ? 8'h00 : 8'h0a);
      foreach (tab[i]) begin
         wr(ADDR_COUNTER_CONTROL, 8'(tab[i][1]));
         wr(8'(8'he5 + tab[i][0]), 8'(8'h44 | (tab[i][2] << 3)));
         repeat (70) @(negedge clk);
         if (tab[i][3] == 0) n = int'(compare_out[tab[i][0]]);
         else hi_len(tab[i][0], n);
         check("compare_out", 16'(n), 16'(tab[i][4]));
      end
      check("flags", 16'(channel_flag[2:1]), 16'h3);
      wr(ADDR_CH1_CONTROL, 8'h04);
      check("irq", 16'(channel_irq[2:1]), 16'h2);
      $display("test compare actions done");
      wr(ADDR_COUNTER_CONTROL, {6'h00, CNT_FREE});
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_CH1_CONTROL, 8'(8'h40 | c));
         rd(ADDR_CH1_VALUE_LOW, 8'h00, 0, v0[7:0]);
         rd(ADDR_CH1_VALUE_HIGH, 8'h00, 0, v0[15:8]);
         u_tccd_pins_model.set_pin(1, 1'b1);
         repeat (12) @(negedge clk);
         rd(ADDR_CH1_VALUE_LOW, 8'h00, 0, v1[7:0]);
         rd(ADDR_CH1_VALUE_HIGH, 8'h00, 0, v1[15:8]);
         u_tccd_pins_model.set_pin(1, 1'b0);
         repeat (12) @(negedge clk);
         rd(ADDR_CH1_VALUE_LOW, 8'h00, 0, v2[7:0]);
         rd(ADDR_CH1_VALUE_HIGH, 8'h00, 0, v2[15:8]);
         check("cap_rise", 16'(v1 !== v0), 16'(c % 2));
         check("cap_fall", c == 3 ? v2 - v1 : 16'(v2 !== v1),
            c == 3 ? 16'd17 : 16'(c == 2));
      end
      $display("test pin capture done");
      wr(ADDR_COUNTER_CONTROL, 8'h00);
      wr(ADDR_RADIO_EVENT_MASK, 8'h04);
      wr(ADDR_CH2_CONTROL, 8'hc1);
      u_tccd_pins_model.fire(8'h08);
      repeat (4) @(negedge clk);
      check("radio_off", 16'(channel_flag[2]), 16'h0);
      u_tccd_pins_model.fire(8'h04);
      repeat (4) @(negedge clk);
      check("radio_on", 16'(channel_flag[2]), 16'h1);
      $display("test radio capture done");
      wr(ADDR_CH0_VALUE_LOW, 8'h00);
      wr(ADDR_CH1_VALUE_LOW, 8'h00);
      wr(ADDR_CH1_VALUE_HIGH, 8'h80);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_CH1_CONTROL, 8'(8'h7c | c));
         check("dsm_cfg", 16'({dsm_interp_en, dsm_shaping_en}),
            16'(~c & 3));
      end
      n = 0;
      repeat (400) @(negedge clk) n += int'(dsm_out);
      check("dsm_density", 16'(n inside {[184:216]}), 16'h1);
      $display("test modulator done");
      final_report();
   end
endmodule
`default_nettype wire
